// file: core/tcr_regs.vh
// Register layout, field positions and reset values of the trace control registers
`ifndef TCR_REGS_VH
`define TCR_REGS_VH
// ----------------------------------------------------------------
// Register selects
// ----------------------------------------------------------------
`define TCR_SEL_SETUP      3'h1
`define TCR_SEL_CAPS       3'h2
`define TCR_SEL_USER       3'h3
`define TCR_SEL_BPT        3'h4
`define TCR_REG_A          5'h17
`define TCR_REG_B          5'h18
// ----------------------------------------------------------------
// Setup fields
// ----------------------------------------------------------------
`define TCR_SRC_BIT        31
`define TCR_KIND_BIT       30
`define TCR_ALLBR_BIT      27
`define TCR_NOOVF_BIT      26
`define TCR_DBG_BIT        25
`define TCR_EXC_BIT        24
`define TCR_KRN_BIT        23
`define TCR_USR_BIT        21
`define TCR_GLOBAL_BIT     4
`define TCR_MODE_HI        3
`define TCR_MODE_LO        1
`define TCR_ON_BIT         0
`define TCR_SETUP_WMASK    32'hcfa0000f
`define TCR_SETUP_RST      32'h00000000
`define TCR_USER_RST       32'h00000000
`define TCR_BPT_RST        32'h00000000
// ----------------------------------------------------------------
// Capability fields and reset values
// ----------------------------------------------------------------
`define TCR_KINDS_HI       6
`define TCR_KINDS_LO       5
`define TCR_KINDS_RST      2'h2
`define TCR_BUFCNT_BIT     4
`define TCR_BUFUSE_BIT     3
// ----------------------------------------------------------------
// Breakpoint trigger fields
// ----------------------------------------------------------------
`define TCR_DBPEN_BIT      31
`define TCR_DATA_BP_TRACE_START_HI       17
`define TCR_DATA_BP_TRACE_START_LO       16
`define TCR_IBPEN_BIT      15
`define TCR_BPT_WMASK      32'h8003803f
`endif

// file: core/tcr_trace_ctrl.v
// Trace control coprocessor registers with user records and breakpoint triggers
`timescale 1ns/10ps
`include "tcr_regs.vh"
module tcr_trace_ctrl
#(
  parameter NUM_IBP = 6,
  parameter NUM_DBP = 2
)
(
  input  wire               REF_CLK,
  input  wire               RST,
  // Coprocessor move port, same clock domain
  input  wire               CP_WR,
  input  wire [4:0]         CP_REG,
  input  wire [2:0]         CP_SEL,
  input  wire [31:0]        CP_WDATA,
  output reg  [31:0]        CP_RDATA,
  // Processor mode, same clock domain
  input  wire               IN_DEBUG,
  input  wire               IN_EXCEPTION,
  input  wire               IN_KERNEL,
  input  wire               IN_USER,
  // Trace control block, external pins
  input  wire               TCB_ON,
  input  wire               TCB_DBG_EN,
  input  wire               TCB_EXC_EN,
  input  wire               TCB_KRN_EN,
  input  wire               TCB_USR_EN,
  input  wire [2:0]         TCB_MODE,
  input  wire [1:0]         TCB_KINDS,
  input  wire               TCB_BUFCNT,
  input  wire               TCB_BUFUSE,
  input  wire [2:0]         TCB_SYNC_PERIOD,
  input  wire               FIFO_NEAR_FULL,
  // Breakpoint hits from the core
  input  wire [NUM_IBP-1:0] IBP_HIT,
  input  wire [NUM_DBP-1:0] DBP_HIT,
  // Outputs to trace logic and pipeline
  output reg                TRACE_ACTIVE,
  output reg  [2:0]         TRACE_MODE,
  output reg                ALL_BRANCH_TRACE,
  output reg                PIPE_STALL,
  output reg                USER_REC_VALID,
  output reg                USER_REC_KIND,
  output reg  [31:0]        USER_REC_DATA
);
  // ----------------------------------------------------------------
  // Pin synchronisers: first stage read only by second
  // ----------------------------------------------------------------
  localparam PW = 16;
  wire [PW-1:0] pin_raw = {TCB_ON, TCB_DBG_EN, TCB_EXC_EN, TCB_KRN_EN, TCB_USR_EN,
                           TCB_MODE, TCB_KINDS, TCB_BUFCNT, TCB_BUFUSE,
                           TCB_SYNC_PERIOD, FIFO_NEAR_FULL};
  reg  [PW-1:0] pin_meta_q;
  reg  [PW-1:0] pin_q;
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      pin_meta_q <= {PW{1'b0}};
      pin_q      <= {PW{1'b0}};
    end
    else
    begin
      pin_meta_q <= pin_raw;
      pin_q      <= pin_meta_q;
    end
  end
  // Synchronised trace block levels, same order as the packed word
  wire       h_on     = pin_q[15];
  wire       h_dbg    = pin_q[14];
  wire       h_exc    = pin_q[13];
  wire       h_krn    = pin_q[12];
  wire       h_usr    = pin_q[11];
  wire [2:0] h_mode   = pin_q[10:8];
  wire [1:0] h_kinds  = pin_q[7:6];
  wire       h_bufcnt = pin_q[5];
  wire       h_bufuse = pin_q[4];
  wire [2:0] h_sync   = pin_q[3:1];
  wire       h_nfull  = pin_q[0];

  // ----------------------------------------------------------------
  // Register select decode
  // ----------------------------------------------------------------
  function is_sel;
    input [4:0] r;
    input [2:0] s;
    input [4:0] want_r;
    input [2:0] want_s;
    begin
      is_sel = (r == want_r) && (s == want_s);
    end
  endfunction
  wire hit_setup = is_sel(CP_REG, CP_SEL, `TCR_REG_A, `TCR_SEL_SETUP);
  wire hit_caps  = is_sel(CP_REG, CP_SEL, `TCR_REG_A, `TCR_SEL_CAPS);
  wire hit_user1 = is_sel(CP_REG, CP_SEL, `TCR_REG_A, `TCR_SEL_USER);
  wire hit_user2 = is_sel(CP_REG, CP_SEL, `TCR_REG_B, `TCR_SEL_USER);
  wire hit_bpt   = is_sel(CP_REG, CP_SEL, `TCR_REG_A, `TCR_SEL_BPT);
  // Either user word written this cycle
  wire user_take = CP_WR & (hit_user1 | hit_user2);

  // ----------------------------------------------------------------
  // Writable state
  // ----------------------------------------------------------------
  reg  [31:0] setup_q;
  reg  [31:0] user1_q;
  reg  [31:0] user2_q;
  reg  [31:0] bpt_q;
  reg  [1:0]  kinds_q;
  // Only writable bits store; space id, global and reserved stay zero
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      setup_q <= `TCR_SETUP_RST;
    else if (CP_WR && hit_setup)
      setup_q <= CP_WDATA & `TCR_SETUP_WMASK;
  end

  // User words read back what software last wrote
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      user1_q <= `TCR_USER_RST;
      user2_q <= `TCR_USER_RST;
    end
    else if (user_take)
    begin
      if (hit_user1)
        user1_q <= CP_WDATA;
      else
        user2_q <= CP_WDATA;
    end
  end

  // Breakpoint trigger setup, reserved bits held at zero
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      bpt_q <= `TCR_BPT_RST;
    else if (CP_WR && hit_bpt)
      bpt_q <= CP_WDATA & `TCR_BPT_WMASK;
  end

  // Supported kinds resets to 10 until the trace block reports
  // Two-cycle hold: the synchroniser still shows its reset zero before that
  reg [1:0] kinds_wait_q;
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      kinds_q      <= `TCR_KINDS_RST;
      kinds_wait_q <= 2'h0;
    end
    else
    begin
      kinds_wait_q <= {kinds_wait_q[0], 1'b1};
      if (kinds_wait_q[1])
        kinds_q <= h_kinds;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  reg [31:0] rd_d;
  always @*
  begin
    rd_d = 32'h00000000;
    if (hit_setup)
    begin
      rd_d = setup_q;
      rd_d[`TCR_GLOBAL_BIT] = 1'b1;
    end
    else if (hit_caps)
    begin
      rd_d[`TCR_KINDS_HI:`TCR_KINDS_LO] = kinds_q;
      rd_d[`TCR_BUFCNT_BIT] = h_bufcnt;
      rd_d[`TCR_BUFUSE_BIT] = h_bufuse;
      rd_d[2:0] = h_sync;
    end
    else if (hit_user1)
      rd_d = user1_q;
    else if (hit_user2)
      rd_d = user2_q;
    else if (hit_bpt)
      rd_d = bpt_q;
  end

  // ----------------------------------------------------------------
  // Effective enables: software bits or trace block pins
  // ----------------------------------------------------------------
  wire       sw_sel  = setup_q[`TCR_SRC_BIT];
  wire       e_on    = sw_sel ? setup_q[`TCR_ON_BIT]  : h_on;
  wire       e_dbg   = sw_sel ? setup_q[`TCR_DBG_BIT] : h_dbg;
  wire       e_exc   = sw_sel ? setup_q[`TCR_EXC_BIT] : h_exc;
  wire       e_krn   = sw_sel ? setup_q[`TCR_KRN_BIT] : h_krn;
  wire       e_usr   = sw_sel ? setup_q[`TCR_USR_BIT] : h_usr;
  wire [2:0] e_mode  = sw_sel ? setup_q[`TCR_MODE_HI:`TCR_MODE_LO] : h_mode;
  // Debug outranks exception, which outranks kernel and user
  reg mode_ok;
  always @*
  begin
    mode_ok = 1'b0;
    if (IN_DEBUG)
      mode_ok = e_dbg;
    else if (IN_EXCEPTION)
      mode_ok = e_exc;
    else if (IN_KERNEL)
      mode_ok = e_krn;
    else if (IN_USER)
      mode_ok = e_usr;
  end

  // ----------------------------------------------------------------
  // Breakpoint start/stop triggers
  // ----------------------------------------------------------------
  wire ib_start;
  wire ib_stop;
  wire db_start;
  wire db_stop;
  tcr_trigger #(.N(NUM_IBP)) u_ibp
  (
    .clk        (REF_CLK),
    .rst        (RST),
    .enable     (bpt_q[`TCR_IBPEN_BIT]),
    .hits       (IBP_HIT),
    .start_mask (bpt_q[NUM_IBP-1:0]),
    .start      (ib_start),
    .stop       (ib_stop)
  );
  tcr_trigger #(.N(NUM_DBP)) u_dbp
  (
    .clk        (REF_CLK),
    .rst        (RST),
    .enable     (bpt_q[`TCR_DBPEN_BIT]),
    .hits       (DBP_HIT),
    .start_mask (bpt_q[`TCR_DATA_BP_TRACE_START_LO+NUM_DBP-1:`TCR_DATA_BP_TRACE_START_LO]),
    .start      (db_start),
    .stop       (db_stop)
  );
  // Trigger gate: open until a stop trigger, reopened by a start
  reg armed_q;
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      armed_q <= 1'b1;
    else if (ib_start | db_start)
      armed_q <= 1'b1;
    else if (ib_stop | db_stop)
      armed_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Read data lags the select by one cycle
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      CP_RDATA <= 32'h00000000;
    else
      CP_RDATA <= rd_d;
  end

  // Trace gating and content seen by the trace logic
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      TRACE_ACTIVE     <= 1'b0;
      TRACE_MODE       <= 3'h0;
      ALL_BRANCH_TRACE <= 1'b0;
    end
    else
    begin
      TRACE_ACTIVE     <= e_on & mode_ok & armed_q;
      TRACE_MODE       <= e_mode;
      ALL_BRANCH_TRACE <= setup_q[`TCR_ALLBR_BIT];
    end
  end

  // Stall only when trace was running the cycle before, so idle cores never hang
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      PIPE_STALL <= 1'b0;
    else
      PIPE_STALL <= setup_q[`TCR_NOOVF_BIT] & h_nfull & TRACE_ACTIVE;
  end

  // One-cycle user record per write; back-to-back writes give back-to-back records
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      USER_REC_VALID <= 1'b0;
      USER_REC_KIND  <= 1'b0;
      USER_REC_DATA  <= 32'h00000000;
    end
    else
    begin
      USER_REC_VALID <= user_take;
      // Kind bit picks record tag; the written word is the data, whichever user register
      USER_REC_KIND  <= setup_q[`TCR_KIND_BIT];
      if (user_take)
        USER_REC_DATA <= CP_WDATA;
    end
  end
endmodule // tcr_trace_ctrl

// file: core/tcr_trigger.v
// Breakpoint trigger to trace start/stop decision
`timescale 1ns/10ps
module tcr_trigger
#(
  parameter N = 6
)
(
  input  wire         clk,
  input  wire         rst,
  input  wire         enable,
  input  wire [N-1:0] hits,
  input  wire [N-1:0] start_mask,
  output reg          start,
  output reg          stop
);
  // ----------------------------------------------------------------
  // Gated hits, start wins when both kinds fire together
  // ----------------------------------------------------------------
  wire [N-1:0] gated = enable ? hits : {N{1'b0}};
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      start <= 1'b0;
      stop  <= 1'b0;
    end
    else
    begin
      start <= |(gated & start_mask);
      stop  <= ~(|(gated & start_mask)) & (|(gated & ~start_mask));
    end
  end
endmodule // tcr_trigger

// file: verif/tcr_tcb_model.sv
// Trace control block stand-in driving enable and status pins
`timescale 1ns/10ps
module tcr_tcb_model
(
  input  wire        clk,
  input  wire [14:0] cfg,
  output reg         on,
  output reg  [3:0]  mode_en,
  output reg  [2:0]  mode,
  output reg  [1:0]  kinds,
  output reg         bufcnt,
  output reg         bufuse,
  output reg  [2:0]  sync
);
  // Pins move just after the edge, like levels from another block
  always @(posedge clk)
  begin
    on      <= cfg[14];
    mode_en <= cfg[13:10];
    mode    <= cfg[9:7];
    kinds   <= cfg[6:5];
    bufcnt  <= cfg[4];
    bufuse  <= cfg[3];
    sync    <= cfg[2:0];
  end
endmodule // tcr_tcb_model

// file: verif/tcr_trace_ctrl_asserts.sv
// Port-level assertions for the trace control registers
`timescale 1ns/10ps
module tcr_trace_ctrl_asserts
(
  input wire        REF_CLK,
  input wire        RST,
  input wire        CP_WR,
  input wire [4:0]  CP_REG,
  input wire [2:0]  CP_SEL,
  input wire [31:0] CP_WDATA,
  input wire [31:0] CP_RDATA,
  input wire        IN_DEBUG,
  input wire        IN_EXCEPTION,
  input wire        IN_KERNEL,
  input wire        IN_USER,
  input wire        TRACE_ACTIVE,
  input wire        PIPE_STALL,
  input wire        USER_REC_VALID,
  input wire [31:0] USER_REC_DATA
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // Select and write steps
  // ----------------------------------------------------------------
  sequence s_sel(logic [4:0] r, logic [2:0] s);
    CP_REG == r && CP_SEL == s;
  endsequence
  sequence s_wr(logic [4:0] r);
    CP_WR && CP_REG == r && CP_SEL == 3'h3;
  endsequence
  sequence s_no_mode;
    !(IN_DEBUG || IN_EXCEPTION || IN_KERNEL || IN_USER);
  endsequence
  a_user_one_rec: assert property (s_wr(5'h17) |=> USER_REC_VALID &&
    USER_REC_DATA == $past(CP_WDATA)) else $error("user word one record wrong");
  a_user_two_rec: assert property (s_wr(5'h18) |=> USER_REC_VALID &&
    USER_REC_DATA == $past(CP_WDATA)) else $error("user word two record wrong");
  a_no_stray_rec: assert property (!(CP_WR && CP_SEL == 3'h3 && CP_REG[4:3] != 2'h0 &&
    (CP_REG == 5'h17 || CP_REG == 5'h18)) |=> !USER_REC_VALID) else $error("stray user record");
  a_setup_fixed: assert property (s_sel(5'h17, 3'h1) |=> CP_RDATA[4] &&
    CP_RDATA[29:28] == 2'h0 && !CP_RDATA[22] && CP_RDATA[20:5] == 16'h0)
    else $error("setup fixed bits wrong");
  a_unmapped_zero: assert property (s_sel(5'h17, 3'h0) |=> CP_RDATA == 32'h0)
    else $error("unmapped select not zero");
  a_caps_upper: assert property (s_sel(5'h17, 3'h2) |=> CP_RDATA[31:7] == 25'h0)
    else $error("capability upper bits set");
  a_bpt_reserved: assert property (s_sel(5'h17, 3'h4) |=> CP_RDATA[30:18] == 13'h0 &&
    CP_RDATA[14:6] == 9'h0) else $error("breakpoint reserved bits set");
  a_stall_traced: assert property (PIPE_STALL |-> $past(TRACE_ACTIVE))
    else $error("stall without trace");
  a_no_mode_off: assert property (s_no_mode [*2] |=> !TRACE_ACTIVE)
    else $error("trace with no mode");
endmodule // tcr_trace_ctrl_asserts

bind tcr_trace_ctrl tcr_trace_ctrl_asserts u_chk (.REF_CLK(REF_CLK), .RST(RST), .CP_WR(CP_WR),
  .CP_REG(CP_REG), .CP_SEL(CP_SEL), .CP_WDATA(CP_WDATA), .CP_RDATA(CP_RDATA),
  .IN_DEBUG(IN_DEBUG), .IN_EXCEPTION(IN_EXCEPTION), .IN_KERNEL(IN_KERNEL), .IN_USER(IN_USER),
  .TRACE_ACTIVE(TRACE_ACTIVE), .PIPE_STALL(PIPE_STALL), .USER_REC_VALID(USER_REC_VALID),
  .USER_REC_DATA(USER_REC_DATA));

// file: verif/testbench.sv
// Self-checking bench for the trace control registers
`timescale 1ns/10ps
module testbench;
  reg         ref_clk;
  reg         rst;
  reg         cp_wr;
  reg  [4:0]  cp_reg;
  reg  [2:0]  cp_sel;
  reg  [31:0] cp_wdata;
  reg  [3:0]  cpu_mode;
  reg  [14:0] tcb_cfg;
  reg         near_full;
  reg  [5:0]  ibp;
  reg  [1:0]  dbp;
  wire [31:0] rdata;
  wire [31:0] rec_data;
  wire [3:0]  t_en;
  wire [2:0]  t_mode;
  wire [2:0]  sync;
  wire [2:0]  tr_mode;
  wire [1:0]  kinds;
  wire        t_on;
  wire        bcnt;
  wire        buse;
  wire        active;
  wire        all_br;
  wire        stall;
  wire        rec_valid;
  wire        rec_kind;
  integer     num_errors;
  integer     check_count;
  integer     i;

  tcr_tcb_model tcb (.clk(ref_clk), .cfg(tcb_cfg), .on(t_on), .mode_en(t_en), .mode(t_mode),
    .kinds(kinds), .bufcnt(bcnt), .bufuse(buse), .sync(sync));
  tcr_trace_ctrl dut (.REF_CLK(ref_clk), .RST(rst), .CP_WR(cp_wr), .CP_REG(cp_reg),
    .CP_SEL(cp_sel), .CP_WDATA(cp_wdata), .CP_RDATA(rdata), .IN_DEBUG(cpu_mode[3]),
    .IN_EXCEPTION(cpu_mode[2]), .IN_KERNEL(cpu_mode[1]), .IN_USER(cpu_mode[0]),
    .TCB_ON(t_on), .TCB_DBG_EN(t_en[3]), .TCB_EXC_EN(t_en[2]), .TCB_KRN_EN(t_en[1]),
    .TCB_USR_EN(t_en[0]), .TCB_MODE(t_mode), .TCB_KINDS(kinds), .TCB_BUFCNT(bcnt),
    .TCB_BUFUSE(buse), .TCB_SYNC_PERIOD(sync), .FIFO_NEAR_FULL(near_full), .IBP_HIT(ibp),
    .DBP_HIT(dbp), .TRACE_ACTIVE(active), .TRACE_MODE(tr_mode), .ALL_BRANCH_TRACE(all_br),
    .PIPE_STALL(stall), .USER_REC_VALID(rec_valid), .USER_REC_KIND(rec_kind),
    .USER_REC_DATA(rec_data));

  task check(input [31:0] seen, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Strobe held until the taking edge, then dropped on it
  task cp_write(input [4:0] r, input [2:0] s, input [31:0] d);
  begin
    @(posedge ref_clk) {cp_wr, cp_reg, cp_sel, cp_wdata} <= {1'b1, r, s, d};
    @(posedge ref_clk) cp_wr <= 1'b0;
  end
  endtask
  task cp_read(input [4:0] r, input [2:0] s, input [31:0] m, input [31:0] e);
  begin
    @(posedge ref_clk) {cp_reg, cp_sel} <= {r, s};
    repeat (2) @(posedge ref_clk);
    #1 check(rdata & m, e);
  end
  endtask
  // Margin covers pin sync, trigger and output stages
  task expect_trace(input a, input [2:0] m);
  begin
    repeat (6) @(posedge ref_clk);
    #1 check(active, a);
    if (a)
      check(tr_mode, m);
  end
  endtask
  task user_wr(input [4:0] r, input [31:0] d, input k);
  begin
    cp_write(r, 3'h3, d);
    #1 check(rec_data, d);
    check({rec_valid, rec_kind}, {1'b1, k});
    // Idle cycle keeps user writes apart
    @(posedge ref_clk);
    #1 check(rec_valid, 1'b0);
  end
  endtask
  task pulse(input [5:0] ib, input [1:0] db);
  begin
    @(posedge ref_clk) {ibp, dbp} <= {ib, db};
    @(posedge ref_clk) {ibp, dbp} <= 8'h00;
  end
  endtask

  task t_regs;
  begin
    cp_read(5'h17, 3'h1, 32'h80000001, 32'h0);
    cp_read(5'h17, 3'h3, 32'hffffffff, 32'h0);
    cp_read(5'h18, 3'h3, 32'hffffffff, 32'h0);
    cp_read(5'h17, 3'h4, 32'hffffffff, 32'h0);
    cp_write(5'h17, 3'h1, 32'hffffffff);
    cp_read(5'h17, 3'h1, 32'hffffffff, 32'hcfa0001f);
    cp_write(5'h17, 3'h4, 32'hffffffff);
    cp_read(5'h17, 3'h4, 32'hffffffff, 32'h8003803f);
    cp_write(5'h17, 3'h0, 32'hffffffff);
    cp_read(5'h17, 3'h0, 32'hffffffff, 32'h0);
    $display("test regs done");
  end
  endtask
  task t_caps;
    reg [6:0] c;
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      c = {i[1:0], i[1], i[0], i[2:0]};
      @(posedge ref_clk) tcb_cfg[6:0] <= c;
      cp_write(5'h17, 3'h2, 32'hffffffff);
      cp_read(5'h17, 3'h2, 32'hffffffff, {25'h0, c});
    end
    $display("test caps done");
  end
  endtask
  task t_user;
  begin
    cp_write(5'h17, 3'h1, 32'h80000001);
    user_wr(5'h17, 32'ha5c30f01, 1'b0);
    cp_write(5'h17, 3'h1, 32'hc0000001);
    user_wr(5'h18, 32'h5a3cf0fe, 1'b1);
    cp_read(5'h17, 3'h3, 32'hffffffff, 32'ha5c30f01);
    cp_read(5'h18, 3'h3, 32'hffffffff, 32'h5a3cf0fe);
    $display("test user done");
  end
  endtask
  // One processor mode at a time against its own enable
  task t_trace;
    reg [31:0] b;
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      b = (i == 3) ? 32'h00200000 : (32'h02000000 >> i);
      @(posedge ref_clk) cpu_mode <= 4'h8 >> i;
      cp_write(5'h17, 3'h1, 32'h8000000b | b);
      expect_trace(1'b1, 3'h5);
      cp_write(5'h17, 3'h1, 32'h8000000b | (32'h03a00000 & ~b));
      expect_trace(1'b0, 3'h5);
      cp_write(5'h17, 3'h1, 32'h8000000a | b);
      expect_trace(1'b0, 3'h5);
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      cp_write(5'h17, 3'h1, 32'h80200001 | (i << 1));
      expect_trace(1'b1, i[2:0]);
    end
    @(posedge ref_clk) cpu_mode <= 4'h0;
    expect_trace(1'b0, 3'h0);
    $display("test trace done");
  end
  endtask
  task t_hw;
  begin
    @(posedge ref_clk) {cpu_mode, tcb_cfg[14:7]} <= {4'h1, 1'b1, 4'h1, 3'h6};
    cp_write(5'h17, 3'h1, 32'h0c000000);
    expect_trace(1'b1, 3'h6);
    check(all_br, 1'b1);
    @(posedge ref_clk) near_full <= 1'b1;
    expect_trace(1'b1, 3'h6);
    check(stall, 1'b1);
    cp_write(5'h17, 3'h1, 32'h00000000);
    expect_trace(1'b1, 3'h6);
    check({all_br, stall}, 2'h0);
    @(posedge ref_clk) {near_full, tcb_cfg[14]} <= 2'h0;
    expect_trace(1'b0, 3'h0);
    $display("test hw done");
  end
  endtask
  task t_bpt;
  begin
    cp_write(5'h17, 3'h1, 32'h80200001);
    cp_write(5'h17, 3'h4, 32'h00008000);
    pulse(6'h01, 2'h0);
    expect_trace(1'b0, 3'h0);
    cp_write(5'h17, 3'h4, 32'h00000020);
    pulse(6'h20, 2'h0);
    expect_trace(1'b0, 3'h0);
    cp_write(5'h17, 3'h4, 32'h00008020);
    pulse(6'h20, 2'h0);
    expect_trace(1'b1, 3'h0);
    cp_write(5'h17, 3'h4, 32'h00000000);
    pulse(6'h00, 2'h1);
    expect_trace(1'b1, 3'h0);
    cp_write(5'h17, 3'h4, 32'h80000000);
    pulse(6'h00, 2'h1);
    expect_trace(1'b0, 3'h0);
    cp_write(5'h17, 3'h4, 32'h80020000);
    pulse(6'h00, 2'h2);
    expect_trace(1'b1, 3'h0);
    $display("test bpt done");
  end
  endtask

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Reset, then the scenarios in turn
  initial
  begin
    num_errors = 0;
    check_count = 0;
    {rst, cp_wr, cp_reg, cp_sel, cp_wdata, cpu_mode, near_full, ibp, dbp} = 55'h0;
    rst = 1'b1;
    tcb_cfg = 15'h0040;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_caps;
    t_user;
    t_trace;
    t_hw;
    t_bpt;
    results;
  end
endmodule // testbench
